// *** rtl/msb_pkg.sv ***
// shared constants and types for the modem register bank
package msb_pkg;
	// ==========================================================
	// clock and ring timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int RING_TICK_NS = 1000000;
	localparam int RING_TICK_CYC = RING_TICK_NS / CLK_PERIOD_NS;
	localparam int RING_CNT_W = 9;
	// ==========================================================
	// register bus
	localparam int AXI_AW = 10;
	localparam int IDX_LSB = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// window locations and modes
	localparam logic [7:0] IDX_WIN_LO = 8'he5;
	localparam logic [7:0] IDX_WIN_HI = 8'he6;
	localparam logic [7:0] IDX_WIN_MODE = 8'he8;
	localparam logic [7:0] IDX_LINE_REV = 8'hf8;
	localparam logic [7:0] IDX_RING_STAT = 8'hc5;
	localparam logic [7:0] MODE_ADDR = 8'h00;
	localparam logic [7:0] MODE_WORD = 8'h01;
	localparam logic [7:0] MODE_TONE = 8'h02;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] WIN_RST = 8'h00;
	localparam int WORD_HI_W = 6;
	// ==========================================================
	// plain byte registers: index and reset value per entry
	localparam int NREG = 34;
	localparam logic [7:0] REG_IDX [NREG] = '{
		8'h07, 8'h0c, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h1f,
		8'h33, 8'h36, 8'h38, 8'h3c, 8'h62, 8'h82, 8'hdf, 8'he0,
		8'he1, 8'he2, 8'he3, 8'he4, 8'heb, 8'hf0, 8'hf1, 8'hf2,
		8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf9,
		8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4};
	localparam logic [7:0] REG_RST [NREG] = '{
		8'h01, 8'h00, 8'h48, 8'h40, 8'h10, 8'h00, 8'h84, 8'h2d,
		8'h80, 8'h30, 8'h38, 8'h04, 8'h00, 8'h00, 8'h00, 8'h22,
		8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1c, 8'h00,
		8'h0f, 8'h08, 8'h00, 8'h10, 8'h20,
		8'h10, 8'hc8, 8'h05, 8'h0a, 8'h02};
	localparam int RI_MIN_PERIOD = 29;
	localparam int RI_MAX_PERIOD = 30;
	localparam int RI_MIN_BURST = 31;
	localparam int RI_ON_TIME = 32;
	localparam int RI_REPEAT = 33;
	// ==========================================================
	// carriers
	typedef logic [NREG-1:0][7:0] msb_regs_t;
	typedef struct packed {
		logic dsp_data_available;
		logic tone_detected_flag;
		logic [4:0] tone_code;
	} msb_dsp_status_s;
	typedef struct packed {
		logic [15:0] addr;
		logic addr_load;
		logic [13:0] word;
		logic word_load;
		logic [7:0] tone_control;
		logic [7:0] detector_enables;
	} msb_dsp_cmd_s;
	typedef struct packed {
		logic [7:0] ring_min_period;
		logic [7:0] ring_max_period;
		logic [7:0] ring_min_burst;
		logic [7:0] ring_on_time;
		logic [7:0] ring_repeat_setting;
	} msb_ring_cfg_s;
	typedef enum logic [1:0] {
		RS_IDLE = 2'b00,
		RS_ON = 2'b01,
		RS_OFF = 2'b11
	} msb_ring_state_e;
endpackage

// *** rtl/msb_byte_regs.sv ***
// plain read/write byte registers of the bank
`timescale 1ns/1ps
`default_nettype none
module msb_byte_regs (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write side
	input wire logic wr_en,
	input wire logic [7:0] wr_idx,
	input wire logic [7:0] wr_data,
	output logic wr_hit,
	// read side
	input wire logic [7:0] rd_idx,
	output logic rd_hit,
	output logic [7:0] rd_data,
	// register contents
	output msb_pkg::msb_regs_t regs
);
	import msb_pkg::*;
	logic [NREG-1:0] wr_sel;
	logic [NREG-1:0] rd_sel;
	// one byte per entry, loaded when its index is written
	for (genvar i = 0; i < NREG; i++) begin : g_reg
		assign wr_sel[i] = (wr_idx == REG_IDX[i]);
		assign rd_sel[i] = (rd_idx == REG_IDX[i]);
		always_ff @(posedge aclk) begin
			if (!aresetn)
				regs[i] <= REG_RST[i];
			else if (wr_en && wr_sel[i])
				regs[i] <= wr_data;
		end
	end
	assign wr_hit = |wr_sel;
	assign rd_hit = |rd_sel;
	// indices are unique, so an or of the selected bytes is enough
	always_comb begin
		rd_data = 8'h00;
		for (int i = 0; i < NREG; i++)
			rd_data = rd_data | (rd_sel[i] ? regs[i] : 8'h00);
	end
endmodule
`default_nettype wire

// *** rtl/msb_ring_detect.sv ***
// ring cadence qualifier
`timescale 1ns/1ps
`default_nettype none
module msb_ring_detect #(
	parameter int TICK_CYCLES = msb_pkg::RING_TICK_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// synchronised burst level and settings
	input wire logic ring_burst,
	input wire msb_pkg::msb_ring_cfg_s cfg,
	// qualified ringing
	output logic ringing
);
	import msb_pkg::*;
	msb_ring_state_e state;
	logic [31:0] tick_cnt;
	logic tick;
	logic burst_q;
	logic [RING_CNT_W-1:0] on_t;
	logic [RING_CNT_W-1:0] off_t;
	logic [RING_CNT_W:0] period;
	logic [7:0] good_cnt;
	logic rise;
	logic good;
	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));
	assign rise = ring_burst && !burst_q;
	assign period = {1'b0, on_t} + {1'b0, off_t};
	// every timing setting must hold for a cadence to count
	assign good = (on_t >= {1'b0, cfg.ring_min_burst}) && // RL7
		(on_t >= {1'b0, cfg.ring_on_time}) &&
		(period >= {2'b00, cfg.ring_min_period}) &&
		(period <= {2'b00, cfg.ring_max_period});
	// millisecond time base
	always_ff @(posedge aclk) begin
		if (!aresetn || tick)
			tick_cnt <= 32'h0;
		else
			tick_cnt <= tick_cnt + 32'h1;
	end
	// cadence state, durations and repeat count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= RS_IDLE;
			burst_q <= 1'b0;
			on_t <= '0;
			off_t <= '0;
			good_cnt <= 8'h00;
			ringing <= 1'b0;
		end else begin
			burst_q <= ring_burst;
			case (state)
			RS_IDLE: begin
				if (rise) begin
					state <= RS_ON;
					on_t <= '0;
					off_t <= '0;
				end
			end
			RS_ON: begin
				if (!ring_burst)
					state <= RS_OFF;
				else if (tick && !(&on_t))
					on_t <= on_t + 1'b1;
			end
			RS_OFF: begin
				if (rise) begin
					state <= RS_ON;
					on_t <= '0;
					off_t <= '0;
					good_cnt <= good ? good_cnt + 8'h1 : 8'h00; // RL7
					ringing <= good && (good_cnt + 8'h1 >=
						cfg.ring_repeat_setting); // RL7
				end else if (off_t > {1'b0, cfg.ring_max_period}) begin
					// silence longer than a whole cadence ends ringing
					state <= RS_IDLE;
					good_cnt <= 8'h00;
					ringing <= 1'b0;
				end else if (tick && !(&off_t))
					off_t <= off_t + 1'b1;
			end
			default: state <= RS_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** rtl/msb_bank.sv ***
// upper register bank with the banked DSP window, on AXI4-Lite
// ==========================================================
// Overview of operation
// RL1 - mode register at e8 selects window meaning
// RL2 - mode 0: e5 write loads address low
// RL3 - mode 0: e6 write loads address high
// RL4 - mode 1: e5 write loads word low
// RL5 - mode 1: e6 write loads word bits 13:8
// RL6 - mode 2: e5 reads status, writes controls
// RL7 - ringing only when all cadence settings met
// RL8 - high byte write passes assembled value on
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module msb_bank #(
	parameter int TICK_CYCLES = msb_pkg::RING_TICK_CYC
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [msb_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// write data channel
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// write response channel
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// read address channel
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [msb_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// read data channel
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// pins
	input wire logic ring_burst_pin,
	input wire logic [3:0] line_revision_pin,
	// dsp side
	input wire msb_pkg::msb_dsp_status_s dsp_status,
	output msb_pkg::msb_dsp_cmd_s dsp_cmd,
	// block state
	output logic ringing,
	output msb_pkg::msb_regs_t plain_regs
);
	import msb_pkg::*;

	// ==========================================================
	// declarations
	logic aw_held;
	logic [7:0] aw_idx_q;
	logic w_held;
	logic [7:0] w_data_q;
	logic w_lane_q;
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic do_write;
	logic wr_en;
	logic [7:0] wr_idx;
	logic [7:0] wr_data;
	logic wr_lane;
	logic wr_plain_hit;
	logic wr_mapped;
	logic [7:0] rd_idx;
	logic rd_plain_hit;
	logic [7:0] rd_plain_data;
	logic rd_mapped;
	logic [7:0] rd_byte;
	logic [7:0] win_mode;
	logic [7:0] addr_lo;
	logic [7:0] word_lo;
	logic win_lo_wr;
	logic win_hi_wr;
	logic ring_meta;
	logic ring_sync;
	logic [3:0] rev_meta;
	logic [3:0] rev_sync;
	msb_ring_cfg_s ring_cfg;
	logic [7:0] status_byte;

	// ==========================================================
	// write path: address and data taken in either order
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	// no new write is taken while a response is still pending
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_idx = aw_held ? aw_idx_q : s_axi_awaddr[IDX_LSB +: 8];
	assign wr_data = w_held ? w_data_q : s_axi_wdata[7:0];
	assign wr_lane = w_held ? w_lane_q : s_axi_wstrb[0];
	assign do_write = (aw_held || aw_hs) && (w_held || w_hs);
	// only byte lane 0 carries register data
	assign wr_en = do_write && wr_lane;
	assign wr_mapped = wr_plain_hit || (wr_idx == IDX_WIN_LO) ||
		(wr_idx == IDX_WIN_HI) || (wr_idx == IDX_WIN_MODE) ||
		(wr_idx == IDX_LINE_REV) || (wr_idx == IDX_RING_STAT);

	// address holding register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_idx_q <= 8'h00;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end else if (aw_hs) begin
			aw_held <= 1'b1;
			aw_idx_q <= s_axi_awaddr[IDX_LSB +: 8];
		end
	end

	// data holding register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data_q <= 8'h00;
			w_lane_q <= 1'b0;
		end else if (do_write) begin
			w_held <= 1'b0;
		end else if (w_hs) begin
			w_held <= 1'b1;
			w_data_q <= s_axi_wdata[7:0];
			w_lane_q <= s_axi_wstrb[0];
		end
	end

	// write response, one cycle after the write lands
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// read path
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign rd_idx = s_axi_araddr[IDX_LSB +: 8];
	// flags sit in bits 7 and 6, bit 5 is always clear
	assign status_byte = {dsp_status.dsp_data_available,
		dsp_status.tone_detected_flag, 1'b0, dsp_status.tone_code}; // RL6

	// read multiplexer; write-only window meanings read as zero
	always_comb begin
		rd_mapped = 1'b1;
		rd_byte = 8'h00;
		if (rd_plain_hit)
			rd_byte = rd_plain_data;
		else if (rd_idx == IDX_WIN_MODE)
			rd_byte = win_mode;
		else if (rd_idx == IDX_WIN_LO)
			rd_byte = (win_mode == MODE_TONE) ? status_byte : 8'h00; // RL6
		else if (rd_idx == IDX_WIN_HI)
			rd_byte = 8'h00;
		else if (rd_idx == IDX_LINE_REV)
			rd_byte = {rev_sync, 4'h0};
		else if (rd_idx == IDX_RING_STAT)
			rd_byte = {7'h00, ringing};
		else
			rd_mapped = 1'b0;
	end

	// read data is captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h0, rd_byte};
			s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// plain registers
	msb_byte_regs u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.wr_hit(wr_plain_hit),
		.rd_idx(rd_idx),
		.rd_hit(rd_plain_hit),
		.rd_data(rd_plain_data),
		.regs(plain_regs)
	);

	// ==========================================================
	// window mode register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			win_mode <= MODE_RST; // RL1
		else if (wr_en && wr_idx == IDX_WIN_MODE)
			win_mode <= wr_data; // RL1
	end

	assign win_lo_wr = wr_en && (wr_idx == IDX_WIN_LO);
	assign win_hi_wr = wr_en && (wr_idx == IDX_WIN_HI);

	// low bytes wait here until the matching high byte arrives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_lo <= WIN_RST;
			word_lo <= WIN_RST;
		end else if (win_lo_wr && win_mode == MODE_ADDR) begin
			addr_lo <= wr_data; // RL2
		end else if (win_lo_wr && win_mode == MODE_WORD) begin
			word_lo <= wr_data; // RL4
		end
	end

	// high byte completes the value and strobes it for one cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dsp_cmd.addr <= {WIN_RST, WIN_RST};
			dsp_cmd.word <= '0;
			dsp_cmd.addr_load <= 1'b0;
			dsp_cmd.word_load <= 1'b0;
		end else begin
			dsp_cmd.addr_load <= win_hi_wr && win_mode == MODE_ADDR; // RL8
			dsp_cmd.word_load <= win_hi_wr && win_mode == MODE_WORD; // RL8
			if (win_hi_wr && win_mode == MODE_ADDR)
				dsp_cmd.addr <= {wr_data, addr_lo}; // RL3
			if (win_hi_wr && win_mode == MODE_WORD)
				dsp_cmd.word <= {wr_data[WORD_HI_W-1:0], word_lo}; // RL5
		end
	end

	// tone controls and detector enables, mode 2 only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dsp_cmd.tone_control <= WIN_RST;
			dsp_cmd.detector_enables <= WIN_RST;
		end else if (win_mode == MODE_TONE) begin
			if (win_lo_wr)
				dsp_cmd.tone_control <= wr_data; // RL6
			if (win_hi_wr)
				dsp_cmd.detector_enables <= wr_data; // RL6
		end
	end

	// ==========================================================
	// pin synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ring_meta <= 1'b0;
			ring_sync <= 1'b0;
			rev_meta <= 4'h0;
			rev_sync <= 4'h0;
		end else begin
			ring_meta <= ring_burst_pin;
			ring_sync <= ring_meta;
			rev_meta <= line_revision_pin;
			rev_sync <= rev_meta;
		end
	end

	// ==========================================================
	// ring qualification
	assign ring_cfg.ring_min_period = plain_regs[RI_MIN_PERIOD];
	assign ring_cfg.ring_max_period = plain_regs[RI_MAX_PERIOD];
	assign ring_cfg.ring_min_burst = plain_regs[RI_MIN_BURST];
	assign ring_cfg.ring_on_time = plain_regs[RI_ON_TIME];
	assign ring_cfg.ring_repeat_setting = plain_regs[RI_REPEAT];

	msb_ring_detect #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_ring (
		.aclk(aclk),
		.aresetn(aresetn),
		.ring_burst(ring_sync),
		.cfg(ring_cfg),
		.ringing(ringing)
	);

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	mode_reset_a: assert property ( // RL1
		!$past(aresetn) |-> win_mode == MODE_RST)
		else $error("window mode not cleared by reset");
	addr_low_a: assert property ( // RL2
		win_lo_wr && win_mode == MODE_ADDR |=> addr_lo == $past(wr_data))
		else $error("address low byte not loaded");
	addr_high_a: assert property ( // RL3
		win_hi_wr && win_mode == MODE_ADDR
		|=> dsp_cmd.addr == {$past(wr_data), $past(addr_lo)})
		else $error("address not assembled from both bytes");
	word_low_a: assert property ( // RL4
		win_lo_wr && win_mode == MODE_WORD |=> word_lo == $past(wr_data))
		else $error("word low byte not loaded");
	word_high_a: assert property ( // RL5
		win_hi_wr && win_mode == MODE_WORD
		|=> dsp_cmd.word[13:8] == $past(wr_data[5:0]) &&
		dsp_cmd.word[7:0] == $past(word_lo))
		else $error("word not assembled from both bytes");
	tone_read_a: assert property ( // RL6
		ar_hs && rd_idx == IDX_WIN_LO && win_mode == MODE_TONE
		|=> s_axi_rvalid && s_axi_rdata[7:0] == $past(status_byte))
		else $error("tone status read wrong");
	// ringing may only rise on the edge that follows a burst start
	ring_edge_a: assert property ( // RL7
		$rose(ringing) |-> $past(ring_sync) && !$past(ring_sync, 2))
		else $error("ringing raised outside a burst start");
	load_pair_a: assert property ( // RL8
		dsp_cmd.addr_load || dsp_cmd.word_load
		|-> $past(win_hi_wr) && !(dsp_cmd.addr_load && dsp_cmd.word_load))
		else $error("dsp load strobe without high byte write");

	addr_load_c: cover property (dsp_cmd.addr_load);
	word_load_c: cover property (dsp_cmd.word_load);
	ringing_c: cover property ($rose(ringing));
	slverr_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
	tone_read_c: cover property (ar_hs && rd_idx == IDX_WIN_LO &&
		win_mode == MODE_TONE);

	// tone control byte follows a low location write in mode 2
	tone_ctrl_a: assert property ( // RL6
		win_lo_wr && win_mode == MODE_TONE
		|=> dsp_cmd.tone_control == $past(wr_data))
		else $error("tone control byte not loaded");
	// modes above 2 must leave every window meaning untouched
	mode_idle_a: assert property ( // RL1
		(win_lo_wr || win_hi_wr) && win_mode > MODE_TONE
		|=> !dsp_cmd.addr_load && !dsp_cmd.word_load &&
		$stable(dsp_cmd.tone_control) &&
		$stable(dsp_cmd.detector_enables))
		else $error("window write acted in an unused mode");
endmodule
`default_nettype wire

// *** test/tb_msb_bank.sv ***
// self-checking bench for the modem register bank with its dsp window
`timescale 1ns/1ps
`default_nettype none
module tb_msb_bank;
	import msb_pkg::*;
	// ==========================================================
	// signals
	localparam int TICK = 4;
	logic aclk, aresetn;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb, line_revision_pin;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, ring_burst_pin, ringing;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	msb_dsp_status_s dsp_status;
	msb_dsp_cmd_s dsp_cmd;
	msb_regs_t plain_regs;
	int error_cnt, n_checks, addr_pulses, word_pulses;
	logic [15:0] seen_addr;
	logic [13:0] seen_word;
	msb_bank #(.TICK_CYCLES(TICK)) i_msb_bank (.aclk(aclk),
		.aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.ring_burst_pin(ring_burst_pin),
		.line_revision_pin(line_revision_pin), .dsp_status(dsp_status),
		.dsp_cmd(dsp_cmd), .ringing(ringing), .plain_regs(plain_regs));
	// ==========================================================
	// clock and load pulse monitor
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// load pulses last one cycle, so each sampled edge counts once
	always @(posedge aclk) begin
		if (aresetn === 1'b1 && dsp_cmd.addr_load === 1'b1) begin
			addr_pulses++;
			seen_addr = dsp_cmd.addr;
		end
		if (aresetn === 1'b1 && dsp_cmd.word_load === 1'b1) begin
			word_pulses++;
			seen_word = dsp_cmd.word;
		end
	end
	// ==========================================================
	// shared tasks
	task check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// write address and data offered together, each dropped when taken
	task axi_wr(input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] st, output logic [1:0] r);
		int n;
		logic aw_ok, w_ok;
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= st;
		s_axi_bready <= 1'b1;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		n = 0;
		while (!(aw_ok && w_ok) && n < 100) begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
				aw_ok = 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
				w_ok = 1'b1;
			end
		end
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 100) error_cnt++;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d);
		axi_wr(idx, d, 4'hf, resp);
	endtask
	task axi_rd(input logic [7:0] idx, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= {idx, 2'b00};
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_arready !== 1'b1 && n < 100);
		s_axi_arvalid <= 1'b0;
		do begin
			@(posedge aclk);
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 100) error_cnt++;
	endtask
	// ==========================================================
	// scenarios
	task test_reset;
		for (int i = 0; i < NREG; i++) begin
			axi_rd(REG_IDX[i], rd, resp);
			check("reset value", rd, {24'h0, REG_RST[i]});
		end
		axi_rd(IDX_WIN_MODE, rd, resp);
		check("mode reset", rd, 32'h0);
		$display("test_reset done");
	endtask
	task test_addr;
		int p;
		p = addr_pulses;
		wr(IDX_WIN_MODE, MODE_ADDR);
		wr(IDX_WIN_LO, 8'h34);
		check("low alone pulses", addr_pulses, p);
		wr(IDX_WIN_HI, 8'h12);
		repeat (2) @(posedge aclk);
		check("address pulses", addr_pulses, p + 1);
		check("address", seen_addr, 16'h1234);
		wr(IDX_WIN_HI, 8'h56);
		repeat (2) @(posedge aclk);
		check("high reuses low", seen_addr, 16'h5634);
		axi_rd(IDX_WIN_LO, rd, resp);
		check("low not readable", rd, 32'h0);
		$display("test_addr done");
	endtask
	task test_word;
		int p;
		p = word_pulses;
		wr(IDX_WIN_MODE, MODE_WORD);
		axi_rd(IDX_WIN_MODE, rd, resp);
		check("mode readback", rd, 32'h1);
		wr(IDX_WIN_LO, 8'hcd);
		wr(IDX_WIN_HI, 8'hff);
		repeat (2) @(posedge aclk);
		check("word pulses", word_pulses, p + 1);
		check("word", seen_word, 14'h3fcd);
		$display("test_word done");
	endtask
	task test_tone;
		int pa, pw;
		pa = addr_pulses;
		pw = word_pulses;
		dsp_status <= '{1'b1, 1'b1, 5'h0a};
		wr(IDX_WIN_MODE, MODE_TONE);
		axi_rd(IDX_WIN_LO, rd, resp);
		check("status byte", rd, 32'hca);
		wr(IDX_WIN_LO, 8'ha5);
		check("tone control", dsp_cmd.tone_control, 8'ha5);
		wr(IDX_WIN_HI, 8'h5a);
		check("enables", dsp_cmd.detector_enables, 8'h5a);
		// an unused mode must leave every window meaning idle
		wr(IDX_WIN_MODE, 8'h03);
		wr(IDX_WIN_LO, 8'h77);
		wr(IDX_WIN_HI, 8'h11);
		axi_rd(IDX_WIN_LO, rd, resp);
		check("mode 3 read", rd, 32'h0);
		check("mode 3 control", dsp_cmd.tone_control, 8'ha5);
		check("no loads", addr_pulses + word_pulses, pa + pw);
		$display("test_tone done");
	endtask
	task test_errors;
		axi_rd(8'h00, rd, resp);
		check("unmapped read resp", resp, RESP_SLVERR);
		check("unmapped read data", rd, 32'h0);
		axi_wr(8'h00, 8'h55, 4'hf, resp);
		check("unmapped write resp", resp, RESP_SLVERR);
		axi_wr(8'he0, 8'h5a, 4'h0, resp);
		check("no strobe resp", resp, RESP_OKAY);
		axi_rd(8'he0, rd, resp);
		check("no strobe kept", rd, 32'h22);
		wr(8'he0, 8'h5a);
		axi_rd(8'he0, rd, resp);
		check("written value", rd, 32'h5a);
		check("plain regs", plain_regs[15], 8'h5a);
		line_revision_pin <= 4'h9;
		repeat (4) @(posedge aclk);
		axi_rd(IDX_LINE_REV, rd, resp);
		check("revision pins", rd[7:4], 4'h9);
		$display("test_errors done");
	endtask
	task burst(input int on_t, input int off_t);
		@(posedge aclk);
		ring_burst_pin <= 1'b1;
		repeat (on_t * TICK) @(posedge aclk);
		ring_burst_pin <= 1'b0;
		repeat (off_t * TICK) @(posedge aclk);
	endtask
	task test_ring;
		wr(8'hc0, 8'h04);
		wr(8'hc1, 8'h1e);
		wr(8'hc2, 8'h03);
		wr(8'hc3, 8'h03);
		wr(8'hc4, 8'h02);
		// bursts shorter than the minimum must never qualify
		repeat (4) burst(1, 11);
		check("short bursts", ringing, 1'b0);
		repeat (4) burst(6, 6);
		check("good cadence", ringing, 1'b1);
		axi_rd(8'hc5, rd, resp);
		check("ring status", rd[0], 1'b1);
		repeat (200) @(posedge aclk);
		check("silence drops", ringing, 1'b0);
		// a burst shorter than the ring-on time must not qualify
		wr(8'hc3, 8'h08);
		repeat (4) burst(6, 6);
		check("on time short", ringing, 1'b0);
		// a cadence longer than the maximum period must not qualify
		wr(8'hc3, 8'h03);
		repeat (4) burst(6, 28);
		check("period too long", ringing, 1'b0);
		$display("test_ring done");
	endtask
	// ==========================================================
	// verdict and main sequence
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		end_sim;
	end
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, ring_burst_pin} = 3'h0;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		line_revision_pin = 4'h0;
		dsp_status = '0;
		error_cnt = 0;
		n_checks = 0;
		addr_pulses = 0;
		word_pulses = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		test_reset;
		test_addr;
		test_word;
		test_tone;
		test_errors;
		test_ring;
		end_sim;
	end
endmodule
`default_nettype wire
